// file: cal_regs.svh
`ifndef CAL_REGS_SVH
`define CAL_REGS_SVH

// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define REG_SEC 3'h0
`define REG_MIN 3'h1
`define REG_HOUR 3'h2
`define REG_DATE 3'h3
`define REG_MONTH 3'h4
`define REG_WDAY 3'h5
`define REG_YEAR 3'h6
`define REG_LOCK 3'h7

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SEC_STOP_BIT 7
`define HOUR_12H_BIT 7
`define HOUR_PM_BIT 5
`define LOCK_BIT 7
`define CMD_DIR_BIT 0

// ----------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------
`define CMD_SINGLE_TOP 4'h8
`define CMD_BURST_TOP 7'h5f
`define CMD_SRST 8'h90
`define SRST_DATA1 8'h0f
`define SRST_DATA2 8'h80

// ----------------------------------------------------------------
// Writable bits and reset values, register 7 down to 0
// ----------------------------------------------------------------
`define WR_MASKS 64'h80ff071f3fbf7fff
`define RESET_REGS 64'h8000010101000080

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_HZ 10000000
`define TICK_S 1
`define SCLK_HALF_CYC 8
`define FRAME_BITS_SINGLE 7'd16
`define FRAME_BITS_BURST 7'd72

// ----------------------------------------------------------------
// Host controller word addresses
// ----------------------------------------------------------------
`define HOST_CTRL 2'h0
`define HOST_DATA_LO 2'h1
`define HOST_DATA_HI 2'h2
`define HOST_STATUS 2'h3

`endif

// file: cal_pkg.sv
package cal_pkg;

  typedef enum logic [3:0] {
    D_CMD = 4'b0001,
    D_WR = 4'b0010,
    D_RD = 4'b0100,
    D_DONE = 4'b1000
  } dev_state_t;

  typedef enum logic [3:0] {
    H_IDLE = 4'b0001,
    H_LOW = 4'b0010,
    H_HIGH = 4'b0100,
    H_GAP = 4'b1000
  } host_state_t;

  typedef logic [7:0][7:0] reg_file_t;

  typedef struct packed {
    logic [1:0] frame_s;
    logic [1:0] sclk_s;
    logic [1:0] dio_s;
    logic sclk_d;
    dev_state_t state;
    logic [2:0] bit_cnt;
    logic [2:0] addr;
    logic burst;
    logic srst;
    logic armed;
    logic [7:0] shreg;
    reg_file_t regs;
    logic [23:0] div;
    logic dout;
    logic oe_n;
  } dev_st_t;

  typedef struct packed {
    host_state_t state;
    logic [3:0] div;
    logic [6:0] idx;
    logic [6:0] total;
    logic [7:0] cmd;
    logic [63:0] data;
    logic rd;
    logic [1:0] dio_s;
    logic frame;
    logic sclk;
    logic dout;
    logic oe_n;
    logic ack;
    logic [31:0] rdata;
  } host_st_t;

endpackage : cal_pkg

// file: cal_link_if.sv
`timescale 1ns/100ps
interface cal_link_if;
  logic frame;
  logic sclk;
  logic host_do;
  logic host_oe_n;
  logic dev_do;
  logic dev_oe_n;
  logic bidir_data_pin;

  // Pull-up when nobody drives; host wins a clash
  assign bidir_data_pin = !host_oe_n ? host_do : (!dev_oe_n ? dev_do : 1'b1);

  modport dev (
    input frame,
    input sclk,
    input bidir_data_pin,
    output dev_do,
    output dev_oe_n
  );

  modport host (
    output frame,
    output sclk,
    output host_do,
    output host_oe_n,
    input bidir_data_pin
  );
endinterface : cal_link_if

// file: cal_device.sv
`timescale 1ns/100ps
`include "cal_regs.svh"
module cal_device #(
  parameter int TICK_DIV = `CLK_HZ * `TICK_S
) (
  input logic ref_clk,
  input logic rst,
  cal_link_if.dev lnk,
  output cal_pkg::reg_file_t calendar,
  output logic standby
);
  import cal_pkg::*;

  localparam reg_file_t WMASK = `WR_MASKS;
  localparam reg_file_t RESET_VAL = `RESET_REGS;
  localparam logic [23:0] DIV_LAST = 24'(TICK_DIV - 1);

  dev_st_t s;
  dev_st_t n;
  logic frame;
  logic rise;
  logic fall;
  logic din;
  logic locked;
  logic [7:0] in_byte;

  // ----------------------------------------------------------------
  // Calendar arithmetic
  // ----------------------------------------------------------------
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] == 4'h9) begin
      bcd_inc = {v[7:4] + 4'h1, 4'h0};
    end else begin
      bcd_inc = {v[7:4], v[3:0] + 4'h1};
    end
  endfunction : bcd_inc

  // Leap test works on BCD year: 2 * tens + units, modulo four
  function automatic logic [7:0] last_day(input logic [7:0] mo,
                                          input logic [7:0] yr);
    logic [1:0] m4;
    m4 = yr[1:0] + {yr[4], 1'b0};
    case (mo)
      8'h02: last_day = (m4 == 2'h0) ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: last_day = 8'h30;
      default: last_day = 8'h31;
    endcase
  endfunction : last_day

  function automatic reg_file_t advance(input reg_file_t r);
    reg_file_t q;
    logic c_min;
    logic c_hour;
    logic c_day;
    logic c_month;
    logic c_year;
    q = r;
    c_min = 1'b0;
    c_hour = 1'b0;
    c_day = 1'b0;
    c_month = 1'b0;
    c_year = 1'b0;
    if (r[`REG_SEC][6:0] == 7'h59) begin
      q[`REG_SEC] = 8'h00;
      c_min = 1'b1;
    end else begin
      q[`REG_SEC] = bcd_inc(r[`REG_SEC]);
    end
    if (c_min) begin
      if (r[`REG_MIN] == 8'h59) begin
        q[`REG_MIN] = 8'h00;
        c_hour = 1'b1;
      end else begin
        q[`REG_MIN] = bcd_inc(r[`REG_MIN]);
      end
    end
    if (c_hour) begin
      if (r[`REG_HOUR][`HOUR_12H_BIT]) begin
        if (r[`REG_HOUR][4:0] == 5'h12) begin
          q[`REG_HOUR] = {r[`REG_HOUR][7:5], 5'h01};
        end else if (r[`REG_HOUR][4:0] == 5'h11) begin
          // Eleven to twelve flips the meridiem; 11 PM ends the day
          q[`REG_HOUR] = {r[`REG_HOUR][7:6], ~r[`REG_HOUR][5], 5'h12};
          c_day = r[`REG_HOUR][`HOUR_PM_BIT];
        end else begin
          q[`REG_HOUR] = bcd_inc(r[`REG_HOUR]);
        end
      end else if (r[`REG_HOUR][5:0] == 6'h23) begin
        q[`REG_HOUR] = 8'h00;
        c_day = 1'b1;
      end else begin
        q[`REG_HOUR] = bcd_inc(r[`REG_HOUR]);
      end
    end
    if (c_day) begin
      q[`REG_WDAY] = (r[`REG_WDAY] == 8'h07) ? 8'h01 :
                     bcd_inc(r[`REG_WDAY]);
      if (r[`REG_DATE] == last_day(r[`REG_MONTH], r[`REG_YEAR])) begin
        q[`REG_DATE] = 8'h01;
        c_month = 1'b1;
      end else begin
        q[`REG_DATE] = bcd_inc(r[`REG_DATE]);
      end
    end
    if (c_month) begin
      if (r[`REG_MONTH] == 8'h12) begin
        q[`REG_MONTH] = 8'h01;
        c_year = 1'b1;
      end else begin
        q[`REG_MONTH] = bcd_inc(r[`REG_MONTH]);
      end
    end
    if (c_year) begin
      q[`REG_YEAR] = (r[`REG_YEAR] == 8'h99) ? 8'h00 :
                     bcd_inc(r[`REG_YEAR]);
    end
    advance = q;
  endfunction : advance

  // ----------------------------------------------------------------
  // Pin sampling, only second stages are read
  // ----------------------------------------------------------------
  assign frame = s.frame_s[1];
  assign rise = s.sclk_s[1] & ~s.sclk_d;
  assign fall = ~s.sclk_s[1] & s.sclk_d;
  assign din = s.dio_s[1];
  assign locked = s.regs[`REG_LOCK][`LOCK_BIT];
  assign in_byte = {din, s.shreg[7:1]};

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    n = s;
    n.frame_s = {s.frame_s[0], lnk.frame};
    n.sclk_s = {s.sclk_s[0], lnk.sclk};
    n.dio_s = {s.dio_s[0], lnk.bidir_data_pin};
    n.sclk_d = s.sclk_s[1];

    // Timekeeping; a serial write in the same cycle overrides the written register, a soft reset all of them
    if (s.regs[`REG_SEC][`SEC_STOP_BIT]) begin
      n.div = 24'h000000;
    end else if (s.div == DIV_LAST) begin
      n.div = 24'h000000;
      n.regs = advance(s.regs);
    end else begin
      n.div = s.div + 24'h000001;
    end

    if (!frame) begin
      n.state = D_CMD;
      n.bit_cnt = 3'h0;
      n.addr = 3'h0;
      n.burst = 1'b0;
      n.srst = 1'b0;
      n.oe_n = 1'b1;
    end else begin
      case (s.state)
        D_CMD: begin
          if (rise) begin
            n.shreg = in_byte;
            n.bit_cnt = s.bit_cnt + 3'h1;
            if (s.bit_cnt == 3'h7) begin
              n.addr = in_byte[3:1];
              n.burst = 1'b0;
              n.srst = 1'b0;
              n.state = D_DONE;
              if (in_byte[7:1] == `CMD_BURST_TOP) begin
                n.burst = 1'b1;
                n.addr = `REG_SEC;
                n.state = in_byte[`CMD_DIR_BIT] ? D_RD : D_WR;
              end else if (in_byte[7:4] == `CMD_SINGLE_TOP) begin
                n.state = in_byte[`CMD_DIR_BIT] ? D_RD : D_WR;
              end else if (in_byte == `CMD_SRST) begin
                n.srst = 1'b1;
                n.state = D_WR;
              end
            end
          end
        end
        D_WR: begin
          if (rise) begin
            n.shreg = in_byte;
            n.bit_cnt = s.bit_cnt + 3'h1;
            if (s.bit_cnt == 3'h7) begin
              if (s.srst) begin
                // Second half only counts if the last soft-reset data byte was the first
                n.armed = (in_byte == `SRST_DATA1);
                if (s.armed && in_byte == `SRST_DATA2) begin
                  n.regs = RESET_VAL;
                end
              end else if (s.addr == `REG_LOCK) begin
                if (!s.burst) begin
                  n.regs[`REG_LOCK] = in_byte & WMASK[`REG_LOCK];
                end
              end else if (!locked) begin
                n.regs[s.addr] = in_byte & WMASK[s.addr];
              end
              if (s.burst && s.addr != `REG_LOCK) begin
                n.addr = s.addr + 3'h1;
              end else begin
                n.state = D_DONE;
              end
            end
          end
        end
        D_RD: begin
          if (fall) begin
            n.dout = s.regs[s.addr][s.bit_cnt];
            n.oe_n = 1'b0;
            n.bit_cnt = s.bit_cnt + 3'h1;
            if (s.bit_cnt == 3'h7 && s.burst) begin
              n.addr = s.addr + 3'h1;
            end
          end
        end
        D_DONE: begin
          n.oe_n = 1'b1;
        end
        default: begin
          n.state = D_CMD;
          n.oe_n = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s <= '{frame_s: 2'h0, sclk_s: 2'h0, dio_s: 2'h0, sclk_d: 1'b0,
             state: D_CMD, bit_cnt: 3'h0, addr: 3'h0, burst: 1'b0,
             srst: 1'b0, armed: 1'b0, shreg: 8'h00, regs: RESET_VAL,
             div: 24'h000000, dout: 1'b0, oe_n: 1'b1};
    end else begin
      s <= n;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign lnk.dev_do = s.dout;
  assign lnk.dev_oe_n = s.oe_n;
  assign calendar = s.regs;
  assign standby = s.regs[`REG_SEC][`SEC_STOP_BIT];

endmodule : cal_device

// file: cal_host.sv
`timescale 1ns/100ps
`include "cal_regs.svh"
module cal_host (
  input logic ref_clk,
  input logic rst,
  cal_link_if.host lnk,
  input logic [1:0] avs_address,
  input logic avs_read,
  input logic avs_write,
  input logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic busy
);
  import cal_pkg::*;

  localparam logic [3:0] HALF_LAST = 4'(`SCLK_HALF_CYC - 1);

  host_st_t s;
  host_st_t n;
  logic tick;
  logic req;
  logic stall;
  logic [6:0] nxt_idx;

  assign tick = (s.div == HALF_LAST);
  assign req = avs_read | avs_write;
  // A new command waits until the link is idle
  assign stall = avs_write & (avs_address == `HOST_CTRL) &
                 (s.state != H_IDLE);
  assign nxt_idx = s.idx + 7'd1;

  always_comb begin
    n = s;
    n.dio_s = {s.dio_s[0], lnk.bidir_data_pin};
    n.ack = 1'b0;
    n.div = (s.state == H_IDLE || tick) ? 4'h0 : s.div + 4'h1;

    // ----------------------------------------------------------------
    // Register slave: one wait cycle, then answer
    // ----------------------------------------------------------------
    if (req && !s.ack && !stall) begin
      n.ack = 1'b1;
      case (avs_address)
        `HOST_CTRL: n.rdata = {24'h000000, s.cmd};
        `HOST_DATA_LO: n.rdata = s.data[31:0];
        `HOST_DATA_HI: n.rdata = s.data[63:32];
        default: n.rdata = {31'h00000000, s.state != H_IDLE};
      endcase
    end
    if (s.ack && avs_write) begin
      case (avs_address)
        `HOST_CTRL: begin
          n.cmd = avs_writedata[7:0];
          n.rd = avs_writedata[`CMD_DIR_BIT];
          n.total = (avs_writedata[7:1] == `CMD_BURST_TOP) ?
                    `FRAME_BITS_BURST : `FRAME_BITS_SINGLE;
          n.idx = 7'd0;
          n.frame = 1'b1;
          n.sclk = 1'b0;
          n.dout = avs_writedata[0];
          n.oe_n = 1'b0;
          n.state = H_LOW;
        end
        `HOST_DATA_LO: n.data[31:0] = avs_writedata;
        `HOST_DATA_HI: n.data[63:32] = avs_writedata;
        default: n.rd = s.rd;
      endcase
    end

    // ----------------------------------------------------------------
    // Serial engine, bit presented a half period before rise
    // ----------------------------------------------------------------
    case (s.state)
      H_IDLE: n.sclk = 1'b0;
      H_LOW: begin
        if (tick) begin
          n.sclk = 1'b1;
          n.state = H_HIGH;
          if (s.rd && s.idx >= 7'd8) begin
            n.data[6'(s.idx - 7'd8)] = s.dio_s[1];
          end
        end
      end
      H_HIGH: begin
        if (tick) begin
          n.sclk = 1'b0;
          if (nxt_idx == s.total) begin
            n.frame = 1'b0;
            n.oe_n = 1'b1;
            n.state = H_GAP;
          end else begin
            n.idx = nxt_idx;
            n.state = H_LOW;
            if (nxt_idx < 7'd8) begin
              n.dout = s.cmd[3'(nxt_idx)];
              n.oe_n = 1'b0;
            end else if (s.rd) begin
              n.oe_n = 1'b1;
            end else begin
              n.dout = s.data[6'(nxt_idx - 7'd8)];
              n.oe_n = 1'b0;
            end
          end
        end
      end
      H_GAP: begin
        if (tick) begin
          n.state = H_IDLE;
        end
      end
      default: begin
        n.state = H_IDLE;
        n.frame = 1'b0;
        n.oe_n = 1'b1;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s <= '{state: H_IDLE, div: 4'h0, idx: 7'd0, total: 7'd0,
             cmd: 8'h00, data: 64'h0, rd: 1'b0, dio_s: 2'h3,
             frame: 1'b0, sclk: 1'b0, dout: 1'b0, oe_n: 1'b1,
             ack: 1'b0, rdata: 32'h00000000};
    end else begin
      s <= n;
    end
  end

  assign lnk.frame = s.frame;
  assign lnk.sclk = s.sclk;
  assign lnk.host_do = s.dout;
  assign lnk.host_oe_n = s.oe_n;
  assign avs_readdata = s.rdata;
  assign avs_waitrequest = req & ~s.ack;
  assign busy = (s.state != H_IDLE);

endmodule : cal_host

// file: cal_link_properties.sv
`timescale 1ns/100ps
module cal_link_checker (
  input logic ref_clk,
  input logic rst,
  input logic frame,
  input logic sclk,
  input logic host_do,
  input logic host_oe_n,
  input logic dev_do,
  input logic dev_oe_n,
  input logic bidir_data_pin
);
  // ------------------------------------------------------------
  // Frame tracking
  // ------------------------------------------------------------
  logic sclk_d;
  logic [6:0] rises;
  logic [7:0] cmd;
  logic valid_cmd;

  // Command is rebuilt from the wire, not taken from either end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sclk_d <= 1'h0;
      rises <= 7'h0;
      cmd <= 8'h0;
    end else begin
      sclk_d <= sclk;
      if (!frame) begin
        rises <= 7'h0;
        cmd <= 8'h0;
      end else if (sclk && !sclk_d) begin
        rises <= rises + 7'h1;
        if (rises < 7'h8) begin
          cmd[rises[2:0]] <= bidir_data_pin;
        end
      end
    end
  end

  assign valid_cmd = cmd[7:4] == 4'h8 || cmd[7:1] == 7'h5f;

  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  AST_SCLK_IDLE: assert property (!frame |-> !sclk)
    else $error("shift clock high outside a frame");
  AST_FLOAT_AFTER_FRAME: assert property (!frame [*4] |-> dev_oe_n)
    else $error("device still drives data after frame end");
  AST_NO_CLASH: assert property (host_oe_n || dev_oe_n)
    else $error("both ends drive the data line");
  AST_HOST_BIT_AT_FALL: assert property (
    !host_oe_n && $changed(host_do) |-> !sclk)
    else $error("host data changed while shift clock high");
  AST_DIO_STABLE_AT_RISE: assert property (
    frame && $rose(sclk) |-> $stable(bidir_data_pin))
    else $error("data line moved at a rising shift edge");
  AST_HALF_PERIOD: assert property (
    $rose(sclk) |-> sclk [*8] ##1 !sclk)
    else $error("shift clock high phase not eight cycles");
  AST_PULSE_COUNT: assert property (
    $fell(frame) |-> rises == 7'd16 || rises == 7'd72)
    else $error("frame closed with a wrong pulse count");
  AST_CMD_NOT_DRIVEN: assert property (
    frame && rises < 7'h8 |-> dev_oe_n)
    else $error("device drove data during the command byte");
  AST_READ_DRIVES: assert property (
    frame && rises == 7'h8 && valid_cmd && cmd[0] && $fell(sclk)
    |-> ##[1:7] !dev_oe_n)
    else $error("read data not driven after command byte");
  AST_WRITE_NO_DRIVE: assert property (
    frame && rises >= 7'h8 && !cmd[0] |-> dev_oe_n)
    else $error("device drove data during a write");
  AST_DEV_BIT_AFTER_FALL: assert property (
    !dev_oe_n && !$past(dev_oe_n) && $changed(dev_do) |-> !sclk)
    else $error("device data changed while shift clock high");
endmodule : cal_link_checker

// file: serial_calendar_port_tb.sv
`timescale 1ns/100ps
`include "cal_regs.svh"
module serial_calendar_port_tb;
  import cal_pkg::*;
  logic ref_clk;
  logic rst;
  logic [1:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic busy;
  logic standby;
  reg_file_t cal;
  logic [7:0] exp_r [8];
  logic [63:0] q64;
  logic [2:0] a;
  int fail_count = 0;
  int n_checks = 0;

  cal_link_if lnk ();
  // Short tick keeps the rollover test brief
  cal_device #(.TICK_DIV(400)) i_cal_device (.ref_clk(ref_clk), .rst(rst),
    .lnk(lnk), .calendar(cal), .standby(standby));
  cal_host i_cal_host (.ref_clk(ref_clk), .rst(rst), .lnk(lnk),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .busy(busy));
  cal_link_checker i_cal_link_checker (.ref_clk(ref_clk), .rst(rst),
    .frame(lnk.frame), .sclk(lnk.sclk), .host_do(lnk.host_do),
    .host_oe_n(lnk.host_oe_n), .dev_do(lnk.dev_do),
    .dev_oe_n(lnk.dev_oe_n), .bidir_data_pin(lnk.bidir_data_pin));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [7:0] bcd(input int v);
    return 8'((v / 10) * 16 + v % 10);
  endfunction : bcd

  function automatic logic [7:0] wcmd(input logic [2:0] ad, input logic rd);
    return {`CMD_SINGLE_TOP, ad, rd};
  endfunction : wcmd

  function automatic logic [7:0] rnd_val(input logic [2:0] ad);
    case (ad)
      3'h1: return bcd($urandom % 60);
      3'h2: return ($urandom % 2) ? (8'h80 | bcd(1 + $urandom % 12) |
        (($urandom % 2) ? 8'h20 : 8'h00)) : bcd($urandom % 24);
      3'h3: return bcd(1 + $urandom % 31);
      3'h4: return bcd(1 + $urandom % 12);
      3'h5: return bcd(1 + $urandom % 7);
      default: return bcd($urandom % 100);
    endcase
  endfunction : rnd_val

  function automatic logic [63:0] exp64();
    logic [63:0] r;
    for (int i = 0; i < 8; i++) begin
      r[8*i +: 8] = exp_r[i];
    end
    return r;
  endfunction : exp64

  task automatic check(input logic [63:0] seen, input logic [63:0] expv);
    n_checks++;
    if (seen !== expv) begin
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, expv);
      fail_count++;
    end
  endtask : check

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : give_verdict

  // Entered just after a rising edge; request held until the edge
  // that sees waitrequest low, data taken at that same edge
  task automatic av(input logic [1:0] ad, input logic wr,
                    input logic [31:0] d, output logic [31:0] q);
    avs_address <= ad;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    do begin
      @(posedge ref_clk);
    end while (avs_waitrequest !== 1'h0);
    q = avs_readdata;
    avs_read <= 1'h0;
    avs_write <= 1'h0;
    // One idle cycle so the next call never re-raises in this step
    @(posedge ref_clk);
  endtask : av

  task automatic xfer(input logic [7:0] c, input logic [63:0] d,
                      output logic [63:0] q);
    logic [31:0] lo;
    logic [31:0] hi;
    int n;
    av(`HOST_DATA_LO, 1'h1, d[31:0], lo);
    av(`HOST_DATA_HI, 1'h1, d[63:32], hi);
    av(`HOST_CTRL, 1'h1, {24'h0, c}, lo);
    n = 0;
    while (busy !== 1'h1 && n < 20) begin
      @(negedge ref_clk);
      n++;
    end
    while (busy === 1'h1) begin
      @(negedge ref_clk);
    end
    @(posedge ref_clk);
    av(`HOST_DATA_LO, 1'h0, 32'h0, lo);
    av(`HOST_DATA_HI, 1'h0, 32'h0, hi);
    q = {hi, lo};
  endtask : xfer

  // ------------------------------------------------------------
  // Clock, watchdog and tests
  // ------------------------------------------------------------
  initial begin
    ref_clk = 1'h0;
    forever #50 ref_clk = ~ref_clk;
  end

  initial begin
    repeat (60000) @(posedge ref_clk);
    fail_count++;
    give_verdict();
  end

  initial begin
    rst = 1'h1;
    avs_address = 2'h0;
    avs_read = 1'h0;
    avs_write = 1'h0;
    avs_writedata = 32'h0;
    void'($urandom(32'h01d621db));
    repeat (3) @(posedge ref_clk);
    rst <= 1'h0;
    @(posedge ref_clk);
    check(cal, `RESET_REGS);
    check(standby, 1'h1);
    $display("test reset_values done");
    xfer(wcmd(`REG_LOCK, 1'h0), 64'h0, q64);
    check(cal[7], 8'h00);
    av(`HOST_CTRL, 1'h0, 32'h0, q64[31:0]);
    check(q64[31:0], {24'h0, wcmd(`REG_LOCK, 1'h0)});
    av(`HOST_STATUS, 1'h0, 32'h0, q64[31:0]);
    check(q64[31:0], 32'h0);
    xfer(wcmd(`REG_MIN, 1'h0), 64'h37, q64);
    check(cal[1], 8'h37);
    xfer(wcmd(`REG_MIN, 1'h1), 64'h0, q64);
    check(q64[7:0], 8'h37);
    xfer(`CMD_SRST, {56'h0, `SRST_DATA1}, q64);
    xfer(`CMD_SRST, {56'h0, `SRST_DATA2}, q64);
    check(cal, `RESET_REGS);
    xfer(wcmd(`REG_MIN, 1'h0), 64'h12, q64);
    check(cal[1], 8'h00);
    $display("test lock_and_soft_reset done");
    xfer(wcmd(`REG_LOCK, 1'h0), 64'h0, q64);
    xfer({`CMD_BURST_TOP, 1'h0}, 64'h80000101012359d9, q64);
    check(cal, 64'h00000101012359d9);
    check(standby, 1'h1);
    xfer(wcmd(`REG_SEC, 1'h0), 64'h59, q64);
    for (int n = 0; n < 3000 && cal[0] !== 8'h00; n++) begin
      @(negedge ref_clk);
    end
    check(standby, 1'h0);
    check(cal[3:0], 32'h02000000);
    $display("test rollover done");
    exp_r[0] = 8'h80;
    exp_r[7] = 8'h00;
    for (int i = 1; i < 7; i++) begin
      exp_r[i] = rnd_val(3'(i));
    end
    xfer({`CMD_BURST_TOP, 1'h0}, exp64() | 64'h8000000000000000, q64);
    check(cal, exp64());
    xfer({`CMD_BURST_TOP, 1'h1}, 64'h0, q64);
    check(q64, exp64());
    for (int i = 0; i < 8; i++) begin
      a = 3'(1 + $urandom % 6);
      exp_r[a] = rnd_val(a);
      xfer(wcmd(a, 1'h0), {56'h0, exp_r[a]}, q64);
      xfer(wcmd(a, 1'h1), 64'h0, q64);
      check(q64[7:0], exp_r[a]);
      check(cal, exp64());
    end
    xfer(8'h00, 64'hff, q64);
    check(cal, exp64());
    $display("test random_access done");
    xfer(wcmd(`REG_LOCK, 1'h0), 64'h80, q64);
    exp_r[7] = 8'h80;
    xfer({`CMD_BURST_TOP, 1'h0}, 64'h0, q64);
    check(cal, exp64());
    $display("test locked_burst done");
    give_verdict();
  end
endmodule : serial_calendar_port_tb
